// ==== mbc_host_model.sv ====
// Purpose: Host side model that reads and writes the control registers
// Assumes: Requests change on the falling edge of clk_sys
// Notes:   Read answers are awaited under a bounded count
`timescale 1ns/10ps
`default_nettype none
module mbc_host_model (
    input wire logic clk_sys,                // System clock
    output var mbc_pkg::mbc_reg_req_t req,   // Register request
    input wire logic [15:0] rdata,           // Read data
    input wire logic rvalid                  // Read data valid
);
    import mbc_pkg::*;
    // ****************************************
    // Bus cycles
    // ****************************************
    // Idle request from time zero, so nothing is taken during reset
    initial begin
        req = '0;
    end
    // One-cycle write strobe; a gap cycle follows, so strobes never merge
    task automatic write_reg(input logic [6:0] idx, input logic [15:0] data);
        logic [15:0] d;
        d = data;
        if (idx == MBC_IDX_MASK) begin
            d[3:2] = 2'b00;
        end
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
        @(negedge clk_sys);
        req = '0;
    endtask : write_reg
    // Read strobe, then wait a few cycles at most for the answer
    task automatic read_reg(input logic [6:0] idx, output logic [15:0] data, output bit ok);
        ok = 1'b0;
        data = '0;
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 16'h0000};
        @(negedge clk_sys);
        req = '0;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                data = rdata;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask : read_reg
endmodule : mbc_host_model
`default_nettype wire

// ==== mbc_irq_pulser.sv ====
// Purpose: Stretches one interrupt request into an active-low pulse of fixed length
// Assumes: Requests arriving during a pulse are merged into it
// Notes:   Output is registered
`timescale 1ns/10ps
`default_nettype none
module mbc_irq_pulser (
    input wire logic clk_sys,         // System clock
    input wire logic rst_b,           // Async reset, active low
    input wire logic fire,            // Request a pulse
    output logic irq_n                // Active-low pulse
);
    import mbc_pkg::*;

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_irq_n;

    // Load counter on request, count down otherwise
    always_comb begin
        next_cnt = cnt;
        if (fire) begin
            next_cnt = 8'(MBC_PULSE_CYC);
        end else if (cnt != 8'h00) begin
            next_cnt = cnt - 8'h01;
        end
        next_irq_n = (next_cnt == 8'h00);
    end

    // Register state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            irq_n <= 1'b1;
        end else begin
            cnt <= next_cnt;
            irq_n <= next_irq_n;
        end
    end
endmodule : mbc_irq_pulser
`default_nettype wire

// ==== mbc_pkg.sv ====
// Purpose: Shared constants and types for the motor bridge control registers
// Assumes: 16-bit registers reached by a 7-bit register index from the serial front end
// Notes:   Offsets, field positions and reset values are named here once
package mbc_pkg;

    // ************************************************************
    // Register indexes
    // ************************************************************
    localparam logic [6:0] MBC_IDX_MASK = 7'h09;
    localparam logic [6:0] MBC_IDX_SCRATCH = 7'h0b;
    localparam logic [6:0] MBC_IDX_GEN = 7'h10;
    localparam logic [6:0] MBC_IDX_CSA = 7'h11;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] MBC_MASK_RST = 16'h0140;
    localparam logic [15:0] MBC_SCRATCH_RST = 16'h0000;
    localparam logic [15:0] MBC_GEN_RST = 16'h0801;
    localparam logic [15:0] MBC_CSA_RST = 16'h0121;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MBC_MSK_CYC = 8;
    localparam int MBC_MSK_WDOFF = 7;
    localparam int MBC_MSK_WDFAIL = 6;
    localparam int MBC_MSK_SPI = 5;
    localparam int MBC_MSK_BD = 4;
    localparam int MBC_MSK_TEMP = 1;
    localparam int MBC_MSK_SUP = 0;
    // Writable bits of the mask register (15:9 read zero)
    localparam logic [15:0] MBC_MASK_WMASK = 16'h01ff;
    // Writable bits of the bridge config (14:13 read zero)
    localparam logic [15:0] MBC_GEN_WMASK = 16'h9fff;
    // Writable bits of the sense config (15:11 read zero)
    localparam logic [15:0] MBC_CSA_WMASK = 16'h07ff;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int MBC_CLK_HZ = 40000000;
    localparam int MBC_PULSE_NS = 100;
    localparam int MBC_PULSE_CYC = (MBC_PULSE_NS * (MBC_CLK_HZ / 1000000) + 999) / 1000;
    localparam int MBC_PERIOD_US = 100;
    localparam int MBC_PERIOD_CYC = MBC_PERIOD_US * (MBC_CLK_HZ / 1000000);

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MBC_GATE_OFF,
        MBC_GATE_FIXED,
        MBC_GATE_ADAPT,
        MBC_GATE_RSVD
    } mbc_gate_mode_t;

    typedef struct packed {
        logic driver_sync_freq_sel;
        logic pump_undervolt_thresh;
        logic transistor_level_sel;
        logic pump_stage_auto_switch;
        logic overvolt_recover_enable;
        logic precharge_step_size;
        mbc_gate_mode_t gate_adapt_mode;
        logic pump_enable;
        logic postcharge_disable;
        logic gate_adapt_filter;
        logic active_fw_detect_enable;
        logic hold_current_sel;
        logic pump_freq_modulation;
    } mbc_bridge_cfg_t;

    typedef struct packed {
        logic bridge_summary_flag;
        logic temp_summary_flag;
        logic supply_summary_flag;
        logic frame_error;
        logic checksum_error;
        logic devmode_wd_fail;
    } mbc_events_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] idx;
        logic [15:0] wdata;
    } mbc_reg_req_t;

endpackage : mbc_pkg

// ==== mbc_regs.sv ====
// Purpose: Interrupt mask, scratch, bridge config and sense config registers
// Assumes: Serial front end delivers decoded one-cycle read and write requests
// Notes:   soft_rst resets the four registers like power-on, but not the interrupt state; restart keeps register contents
`timescale 1ns/10ps
`default_nettype none

module mbc_regs (
    input wire logic clk_sys,                 // System clock, 40 MHz
    input wire logic rst_b,                   // Async power-on reset, active low
    input wire logic soft_rst,                // Soft reset request, one cycle
    input wire logic normal_mode,             // Device in normal operating mode
    input wire logic devmode,                 // Software development mode active
    input wire logic timer_assigned,          // Cyclic timer assigned as wake source
    input wire logic timer_on_nonzero,        // Cyclic timer on-time nonzero
    input wire mbc_pkg::mbc_reg_req_t req,    // Register access request
    input wire mbc_pkg::mbc_events_t evt,     // Event levels from the device
    output logic [15:0] rdata,                // Read data
    output logic rvalid,                      // Read data valid, one cycle
    output logic irq_out_n,                   // Interrupt output, active low
    output logic devmode_watchdog_off,        // Watchdog disabled in devmode
    output logic timer_run,                   // Cyclic timer running
    output var mbc_pkg::mbc_bridge_cfg_t bridge_cfg, // Decoded bridge configuration
    output logic [15:0] sense_cfg             // Current-sense configuration word
);
    import mbc_pkg::*;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [15:0] event_mask_control;
    logic [15:0] host_scratch_store;
    logic [15:0] bridge_general_config;
    logic [15:0] current_sense_config;
    logic [15:0] next_mask;
    logic [15:0] next_scratch;
    logic [15:0] next_gen;
    logic [15:0] next_csa;
    logic [15:0] next_rdata;
    logic next_rvalid;

    // Writes and soft reset compute next register values
    always_comb begin
        next_mask = event_mask_control;
        next_scratch = host_scratch_store;
        next_gen = bridge_general_config;
        next_csa = current_sense_config;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        if (soft_rst) begin
            next_mask = MBC_MASK_RST;
            next_scratch = MBC_SCRATCH_RST;
            next_gen = MBC_GEN_RST;
            next_csa = MBC_CSA_RST;
        end else if (req.wr) begin
            case (req.idx)
                MBC_IDX_MASK: next_mask = req.wdata & MBC_MASK_WMASK;
                MBC_IDX_SCRATCH: begin
                    if (normal_mode) begin
                        next_scratch = req.wdata;
                    end
                end
                MBC_IDX_GEN: next_gen = req.wdata & MBC_GEN_WMASK;
                MBC_IDX_CSA: next_csa = req.wdata & MBC_CSA_WMASK;
                default: next_gen = bridge_general_config;
            endcase
        end
        // Reads return zero for unmapped indexes and a locked scratch
        if (req.rd) begin
            next_rvalid = 1'b1;
            case (req.idx)
                MBC_IDX_MASK: next_rdata = event_mask_control;
                MBC_IDX_SCRATCH: next_rdata = normal_mode ? host_scratch_store : 16'h0000;
                MBC_IDX_GEN: next_rdata = bridge_general_config;
                MBC_IDX_CSA: next_rdata = current_sense_config;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // only rst_b and soft_rst clear scratch; mode changes do not
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            event_mask_control <= MBC_MASK_RST;
            host_scratch_store <= MBC_SCRATCH_RST;
            bridge_general_config <= MBC_GEN_RST;
            current_sense_config <= MBC_CSA_RST;
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            event_mask_control <= next_mask;
            host_scratch_store <= next_scratch;
            bridge_general_config <= next_gen;
            current_sense_config <= next_csa;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ************************************************************
    // Bridge configuration decode
    // ************************************************************
    mbc_bridge_cfg_t next_cfg;
    logic next_wd_off;
    logic [15:0] g;

    // Fields are driven out registered so that outputs come from flops
    always_comb begin
        g = bridge_general_config;
        next_cfg.driver_sync_freq_sel = g[15];
        next_cfg.pump_undervolt_thresh = g[12];
        next_cfg.transistor_level_sel = g[11];
        next_cfg.pump_stage_auto_switch = g[10];
        next_cfg.overvolt_recover_enable = g[9];
        next_cfg.precharge_step_size = g[8];
        next_cfg.gate_adapt_mode = mbc_gate_mode_t'(g[7:6]);
        next_cfg.pump_enable = g[5];
        next_cfg.postcharge_disable = g[4];
        next_cfg.gate_adapt_filter = g[3];
        next_cfg.active_fw_detect_enable = g[2];
        next_cfg.hold_current_sel = g[1];
        next_cfg.pump_freq_modulation = g[0];
        next_wd_off = devmode & event_mask_control[MBC_MSK_WDOFF];
    end

    // Register decoded outputs
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // Built from the register reset word, so decode and register agree in reset
            bridge_cfg <= mbc_bridge_cfg_t'({MBC_GEN_RST[15], MBC_GEN_RST[12:0]});
            devmode_watchdog_off <= 1'b0;
            sense_cfg <= MBC_CSA_RST;
        end else begin
            bridge_cfg <= next_cfg;
            devmode_watchdog_off <= next_wd_off;
            sense_cfg <= current_sense_config;
        end
    end

    // ************************************************************
    // Interrupt generation
    // ************************************************************
    mbc_events_t evt_d;
    logic [5:0] pending;
    logic [5:0] next_pending;
    logic [5:0] rise;
    logic [5:0] en;
    logic [12:0] per_cnt;
    logic [12:0] next_per_cnt;
    logic fire;
    logic next_timer_run;

    // Rising edges of each event; pending clears when the event level drops
    always_comb begin
        en = {event_mask_control[MBC_MSK_BD], event_mask_control[MBC_MSK_TEMP],
              event_mask_control[MBC_MSK_SUP], event_mask_control[MBC_MSK_SPI],
              event_mask_control[MBC_MSK_SPI], event_mask_control[MBC_MSK_WDFAIL]};
        // each new edge counts even if already pending
        rise = evt & ~evt_d;
        // watchdog fail counts only in devmode
        rise[0] = rise[0] & devmode;
        // Set wins over clear
        next_pending = (pending & evt) | (rise & en);
        fire = |(rise & en);
        next_per_cnt = per_cnt;
        if (event_mask_control[MBC_MSK_CYC] && (pending != 6'h00)) begin
            if (per_cnt == 13'(MBC_PERIOD_CYC - 1)) begin
                next_per_cnt = 13'h0000;
                fire = 1'b1;
            end else begin
                next_per_cnt = per_cnt + 13'h0001;
            end
        end else begin
            next_per_cnt = 13'h0000;
        end
        // timer runs when assigned and on-time nonzero
        next_timer_run = timer_assigned & timer_on_nonzero;
    end

    // Register event history
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            evt_d <= '0;
            pending <= 6'h00;
            per_cnt <= 13'h0000;
            timer_run <= 1'b0;
        end else begin
            evt_d <= evt;
            pending <= next_pending;
            per_cnt <= next_per_cnt;
            timer_run <= next_timer_run;
        end
    end

    // Pulse shaper drives the interrupt pin
    // Limitation: an event inside a running pulse stretches it, so the host sees one fall
    mbc_irq_pulser u_pulser (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .fire(fire),
        .irq_n(irq_out_n)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    // frame error pulses when enabled
    chk_spi_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (evt.frame_error && !evt_d.frame_error && event_mask_control[MBC_MSK_SPI])
        |=> ##1 !irq_out_n) else $error("frame error gave no pulse");
    chk_bd_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (evt.bridge_summary_flag && !evt_d.bridge_summary_flag
         && event_mask_control[MBC_MSK_BD]) |=> ##1 !irq_out_n)
        else $error("bridge flag gave no pulse");
    chk_wd_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (evt.devmode_wd_fail && !evt_d.devmode_wd_fail && devmode
         && event_mask_control[MBC_MSK_WDFAIL]) |=> ##1 !irq_out_n)
        else $error("watchdog fail gave no pulse");
    chk_cyc_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !event_mask_control[MBC_MSK_CYC] |=> per_cnt == 13'h0000)
        else $error("periodic counter ran while disabled");
    chk_mask_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        event_mask_control[15:9] == 7'h00) else $error("mask upper bits set");
    chk_scr_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!normal_mode && !soft_rst) |=> $stable(host_scratch_store))
        else $error("scratch changed outside normal mode");
    chk_scr_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        soft_rst |=> host_scratch_store == MBC_SCRATCH_RST)
        else $error("scratch not cleared");
    // watchdog off follows mask in devmode
    chk_wd_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 devmode_watchdog_off == $past(devmode & event_mask_control[MBC_MSK_WDOFF]))
        else $error("watchdog off mismatch");
    chk_pump_en: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 bridge_cfg.pump_enable == $past(bridge_general_config[5]))
        else $error("pump enable mismatch");
    chk_timer_run: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !timer_assigned |=> !timer_run) else $error("timer ran unassigned");
    // periodic wrap drives the pin low
    chk_cyc_fire: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (event_mask_control[MBC_MSK_CYC] && pending != 6'h00
         && per_cnt == 13'(MBC_PERIOD_CYC - 1)) |=> !irq_out_n)
        else $error("periodic wrap gave no pulse");
    // all sources masked keeps the pin idle
    chk_masked_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (irq_out_n && (event_mask_control & 16'h0173) == 16'h0000) |=> irq_out_n)
        else $error("pulse with all sources masked");
    // only host writes and soft reset alter scratch
    chk_scr_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!soft_rst && !(req.wr && req.idx == MBC_IDX_SCRATCH && normal_mode))
        |=> $stable(host_scratch_store)) else $error("scratch changed by device");
    chk_freq_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 bridge_cfg.driver_sync_freq_sel == $past(bridge_general_config[15]))
        else $error("sync frequency select mismatch");
endmodule : mbc_regs
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the motor bridge control registers
// Assumes: Inputs change on the falling clock edge
// Notes:   One task per scenario; period counts use package constants
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mbc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic soft_rst = 1'b0;
    logic normal_mode = 1'b1;
    logic devmode = 1'b0;
    logic timer_assigned = 1'b0;
    logic timer_on_nonzero = 1'b0;
    mbc_events_t evt = '0;
    mbc_reg_req_t req;
    logic [15:0] rdata;
    logic rvalid;
    logic irq_out_n;
    logic devmode_watchdog_off;
    logic timer_run;
    mbc_bridge_cfg_t bridge_cfg;
    logic [15:0] sense_cfg;
    int bad_count = 0;
    int checked = 0;
    // ****************************************
    // Clock and instances
    // ****************************************
    // 25 ns period
    always #12.5 clk_sys = ~clk_sys;
    mbc_regs u_mbc_regs (.clk_sys(clk_sys), .rst_b(rst_b), .soft_rst(soft_rst),
        .normal_mode(normal_mode), .devmode(devmode), .timer_assigned(timer_assigned),
        .timer_on_nonzero(timer_on_nonzero), .req(req), .evt(evt), .rdata(rdata),
        .rvalid(rvalid), .irq_out_n(irq_out_n), .devmode_watchdog_off(devmode_watchdog_off),
        .timer_run(timer_run), .bridge_cfg(bridge_cfg), .sense_cfg(sense_cfg));
    mbc_host_model u_mbc_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata),
        .rvalid(rvalid));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("counts: checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] idx, input logic [15:0] data);
        u_mbc_host_model.write_reg(idx, data);
    endtask : wr
    // A missing answer ends the run, since later reads would all slip
    task automatic rd_chk(input string what, input logic [6:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        bit ok;
        u_mbc_host_model.read_reg(idx, d, ok);
        if (!ok) begin
            bad_count++;
            $display("mismatch %s exp rvalid got none", what);
            complete_run();
        end else begin
            chk(what, exp, d);
        end
    endtask : rd_chk
    // Expected decode: bit 15 then bits 12:0
    function automatic logic [15:0] dec(input logic [15:0] v);
        return {2'b00, v[15], v[12:0]};
    endfunction : dec
    task automatic pulse_soft();
        @(negedge clk_sys);
        soft_rst = 1'b1;
        @(negedge clk_sys);
        soft_rst = 1'b0;
    endtask : pulse_soft
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk("mask reset", MBC_IDX_MASK, 16'h0140);
        rd_chk("scratch reset", MBC_IDX_SCRATCH, 16'h0000);
        rd_chk("config reset", MBC_IDX_GEN, 16'h0801);
        chk("config decode", dec(16'h0801), {2'b00, bridge_cfg});
        $display("test reset done");
    endtask : t_reset
    // Walk a one through every config bit, then every gate mode
    task automatic t_gen();
        logic [15:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 16'h0001 << i;
            wr(MBC_IDX_GEN, v);
            rd_chk("config bit", MBC_IDX_GEN, v & 16'h9fff);
            chk("config field", dec(v & 16'h9fff), {2'b00, bridge_cfg});
        end
        for (int m = 0; m < 4; m++) begin
            wr(MBC_IDX_GEN, 16'(m) << 6);
            rd_chk("gate word", MBC_IDX_GEN, 16'(m) << 6);
            chk("gate mode", 16'(m), {14'h0000, bridge_cfg.gate_adapt_mode});
        end
        $display("test config done");
    endtask : t_gen
    task automatic t_scratch();
        wr(MBC_IDX_MASK, 16'hffff);
        rd_chk("mask top zero", MBC_IDX_MASK, 16'h01f3);
        wr(MBC_IDX_SCRATCH, 16'ha5c3);
        rd_chk("scratch rw", MBC_IDX_SCRATCH, 16'ha5c3);
        normal_mode = 1'b0;
        wr(MBC_IDX_SCRATCH, 16'h1234);
        rd_chk("scratch locked", MBC_IDX_SCRATCH, 16'h0000);
        normal_mode = 1'b1;
        rd_chk("scratch kept", MBC_IDX_SCRATCH, 16'ha5c3);
        pulse_soft();
        rd_chk("scratch soft", MBC_IDX_SCRATCH, 16'h0000);
        rd_chk("mask soft", MBC_IDX_MASK, 16'h0140);
        rd_chk("config soft", MBC_IDX_GEN, 16'h0801);
        wr(MBC_IDX_CSA, 16'hffff);
        rd_chk("sense word", MBC_IDX_CSA, 16'h07ff);
        chk("sense out", 16'h07ff, sense_cfg);
        rd_chk("unmapped", 7'h20, 16'h0000);
        $display("test scratch done");
    endtask : t_scratch
    // Levels combine with an and; all four input pairs are tried
    task automatic t_levels();
        for (int k = 0; k < 4; k++) begin
            wr(MBC_IDX_MASK, 16'(k & 1) << 7);
            devmode = k[1];
            timer_assigned = k[0];
            timer_on_nonzero = k[1];
            repeat (3) @(negedge clk_sys);
            chk("wd off", 16'(k == 3), {15'h0000, devmode_watchdog_off});
            chk("timer run", 16'(k == 3), {15'h0000, timer_run});
        end
        $display("test levels done");
    endtask : t_levels
    // Rise, fall, rise again: an enabled source gives two 4-cycle pulses
    task automatic t_irq(input int e, input int mb, input bit en);
        int falls;
        int lows;
        logic prev;
        falls = 0;
        lows = 0;
        devmode = 1'b1;
        wr(MBC_IDX_MASK, en ? 16'h0001 << mb : 16'h00f3 & ~(16'h0001 << mb));
        prev = irq_out_n;
        for (int c = 0; c < 30; c++) begin
            @(negedge clk_sys);
            if (c == 0 || c == 14) evt[e] = 1'b1;
            if (c == 8) evt = '0;
            lows += int'(irq_out_n === 1'b0);
            falls += int'(prev === 1'b1 && irq_out_n === 1'b0);
            prev = irq_out_n;
        end
        evt = '0;
        chk("irq falls", en ? 16'h0002 : 16'h0000, falls[15:0]);
        chk("irq low cycles", en ? 16'h0008 : 16'h0000, lows[15:0]);
    endtask : t_irq
    // Pending level held: repeats only while the periodic bit is set
    task automatic t_periodic(input bit on);
        int falls;
        logic prev;
        falls = 0;
        wr(MBC_IDX_MASK, on ? 16'h0101 : 16'h0001);
        evt.supply_summary_flag = 1'b1;
        prev = irq_out_n;
        repeat (2 * MBC_PERIOD_CYC + 100) begin
            @(negedge clk_sys);
            falls += int'(prev === 1'b1 && irq_out_n === 1'b0);
            prev = irq_out_n;
        end
        evt = '0;
        chk("periodic", {15'h0000, on}, {15'h0000, falls >= 2});
    endtask : t_periodic
    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    initial begin
        repeat (16) @(negedge clk_sys);
        chk("config in reset", dec(16'h0801), {2'b00, bridge_cfg});
        chk("irq in reset", 16'h0001, {15'h0000, irq_out_n});
        rst_b = 1'b1;
        t_reset();
        t_gen();
        t_scratch();
        t_levels();
        t_irq(5, MBC_MSK_BD, 1'b1);
        t_irq(4, MBC_MSK_TEMP, 1'b1);
        t_irq(3, MBC_MSK_SUP, 1'b1);
        t_irq(2, MBC_MSK_SPI, 1'b1);
        t_irq(1, MBC_MSK_SPI, 1'b1);
        t_irq(0, MBC_MSK_WDFAIL, 1'b1);
        for (int e = 0; e < 6; e++) begin
            t_irq(e, e == 0 ? 6 : e < 3 ? 5 : e == 3 ? 0 : e == 4 ? 1 : 4, 1'b0);
        end
        $display("test irq done");
        t_periodic(1'b1);
        t_periodic(1'b0);
        $display("test periodic done");
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        $display("mismatch run length exp end got timeout");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
